// [src/cps_slave.sv]
// Purpose: fieldbus slave image logic of a machine control panel
// Assumes: master reaches the images over APB; panel pins are asynchronous
// Notes: led output shows flash, version or the master's led image
`timescale 1ns/1ns
`default_nettype none
module cps_slave
  import cps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [63:0] keys_in,
  input wire logic [15:0] hw1_count_in,
  input wire logic [15:0] hw2_count_in,
  input wire logic hw1_present,
  input wire logic hw2_present,
  input wire logic [15:0] direct_keys_in,
  input wire logic [5:0] cust_keys_in,
  input wire logic [7:0] rotary1_in,
  input wire logic [7:0] rotary2_in,
  input wire logic [9:0] rear_selector_switch,
  output logic [63:0] led_out,
  output logic [7:0] cust_led_out,
  output logic fieldbus_mode,
  output logic std_hardware,
  output logic [6:0] station_addr
);
  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam int unsigned SW = 64 + 32 + 2 + 16 + 6 + 16 + 10;
  logic [SW-1:0] raw, s1_q, s2_q, s3_q, st_q;
  assign raw = {keys_in, hw1_count_in, hw2_count_in, hw1_present, hw2_present,
                direct_keys_in, cust_keys_in, rotary1_in, rotary2_in, rear_selector_switch};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      st_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= (s2_q & s3_q) | (st_q & (s2_q | s3_q));
    end
  end
  logic [63:0] keys;
  logic [15:0] hw1, hw2, dkeys;
  logic hw1_on, hw2_on;
  logic [5:0] ckeys;
  logic [7:0] rot1, rot2;
  logic [9:0] sel;
  assign {keys, hw1, hw2, hw1_on, hw2_on, dkeys, ckeys, rot1, rot2, sel} = st_q;

  ////////////////////////////////////////////////////////////////////////
  // selector capture
  logic sel_done_q;
  logic [2:0] sel_wait_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_wait_q <= 3'h0;
      sel_done_q <= 1'b0;
      fieldbus_mode <= 1'b0;
      std_hardware <= 1'b0;
      station_addr <= 7'h00;
    end else if (!sel_done_q) begin
      sel_wait_q <= sel_wait_q + 3'h1;
      if (sel_wait_q == 3'h4) begin
        sel_done_q <= 1'b1;
        fieldbus_mode <= sel[9] & sel[8];
        std_hardware <= ~sel[7];
        station_addr <= sel[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input image, 17 bytes
  logic [7:0] in_img [IN_BYTES];
  always_comb begin
    for (int i = 0; i < STD_BYTES; i++) begin
      in_img[i] = keys[i*8 +: 8];
    end
    in_img[HW_BASE] = hw1_on ? hw1[15:8] : 8'h00;
    in_img[HW_BASE+1] = hw1_on ? hw1[7:0] : 8'h00;
    in_img[HW_BASE+2] = hw2_on ? hw2[15:8] : 8'h00;
    in_img[HW_BASE+3] = hw2_on ? hw2[7:0] : 8'h00;
    in_img[ADD_BASE] = dkeys[7:0];
    in_img[ADD_BASE+1] = dkeys[15:8];
    in_img[ADD_BASE+2] = {2'b00, ckeys};
    in_img[ADD_BASE+3] = rot1;
    in_img[ADD_BASE+4] = rot2;
  end
  function automatic logic [31:0] in_word(input logic [2:0] w, input logic [7:0] img [IN_BYTES]);
    logic [31:0] r;
    r = 32'h0;
    for (int b = 0; b < 4; b++) begin
      if (w * 4 + b < IN_BYTES) begin
        r[b*8 +: 8] = img[w*4+b];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb slave
  cps_img_if img ();
  cps_out_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .bus(img)
  );
  logic setup, is_in, is_out;
  logic comm_q;
  logic rd_pend_q;
  logic [1:0] mode_code;
  logic [31:0] rd_word;
  localparam logic [7:0] IN_SPAN = 8'(((IN_BYTES + 3) / 4) * 4);
  localparam logic [7:0] OUT_SPAN = 8'(((OUT_BYTES + 3) / 4) * 4);
  typedef enum {CPS_REG_IN, CPS_REG_OUT, CPS_REG_CTRL, CPS_REG_STAT, CPS_REG_VER, CPS_REG_NONE} cps_reg_t;
  // address decode, shared by the error flag, the write strobe and the read mux
  function automatic cps_reg_t reg_of(input logic [7:0] a);
    cps_reg_t r;
    r = CPS_REG_NONE;
    if (a[1:0] != 2'b00) begin
      r = CPS_REG_NONE;
    end else if ((a - IN_BASE) < IN_SPAN) begin
      r = CPS_REG_IN;
    end else if ((a - OUT_BASE) < OUT_SPAN) begin
      r = CPS_REG_OUT;
    end else if (a == CTRL_ADDR) begin
      r = CPS_REG_CTRL;
    end else if (a == STAT_ADDR) begin
      r = CPS_REG_STAT;
    end else if (a == VER_ADDR) begin
      r = CPS_REG_VER;
    end
    return r;
  endfunction
  cps_reg_t reg_sel;
  assign reg_sel = reg_of(paddr);
  assign setup = psel && !penable;
  assign is_in = reg_sel == CPS_REG_IN;
  assign is_out = reg_sel == CPS_REG_OUT;
  assign img.we = psel && penable && pready && pwrite && is_out;
  assign img.waddr = paddr[3:2];
  assign img.wdata = (paddr[3:2] == 2'h2) ? {16'h0, pwdata[15:8], 8'h00} : pwdata;
  assign img.raddr = paddr[3:2];
  // read word, registered into prdata on the access cycle
  always_comb begin
    rd_word = 32'h0;
    case (reg_sel)
      CPS_REG_IN: begin
        rd_word = in_word(paddr[4:2], in_img);
      end
      CPS_REG_OUT: begin
        rd_word = img.rdata;
      end
      CPS_REG_CTRL: begin
        rd_word = {31'h0, comm_q};
      end
      CPS_REG_STAT: begin
        rd_word = {20'h0, sel_done_q, station_addr, std_hardware, fieldbus_mode, mode_code};
      end
      CPS_REG_VER: begin
        rd_word = {20'h0, VER_MAJOR, VER_MINOR, VER_PATCH};
      end
      default: begin
        rd_word = 32'h0;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      rd_pend_q <= 1'b0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (setup) begin
        rd_pend_q <= 1'b1;
      end else if (rd_pend_q && psel) begin
        rd_pend_q <= 1'b0;
        pready <= 1'b1;
        pslverr <= (reg_sel == CPS_REG_NONE);
        prdata <= pwrite ? 32'h0 : rd_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // exchange established flag: set by any master access, except that a control write loads it from pwdata bit 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comm_q <= 1'b0;
    end else if (psel && penable && pready) begin
      if (pwrite && paddr == CTRL_ADDR) begin
        comm_q <= pwdata[0];
      end else begin
        comm_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // led mode and flashing
  cps_mode_t mode_q;
  logic [23:0] flash_cnt_q;
  logic blink_q;
  logic ver_keys;
  assign ver_keys = keys[FEED_STOP_BIT] & keys[FEED_EN_BIT];
  assign mode_code = (mode_q == CPS_FLASH) ? 2'h0 : (mode_q == CPS_RUN) ? 2'h1 : 2'h2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt_q <= 24'h0;
      blink_q <= 1'b0;
    end else if (flash_cnt_q == 24'(FLASH_HALF_CYC - 1)) begin
      flash_cnt_q <= 24'h0;
      blink_q <= ~blink_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 24'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= CPS_FLASH;
    end else begin
      case (mode_q)
        CPS_FLASH: begin
          if (ver_keys) mode_q <= CPS_VERSION;
          else if (comm_q) mode_q <= CPS_RUN;
        end
        CPS_RUN: begin
          if (ver_keys) mode_q <= CPS_VERSION;
          else if (!comm_q) mode_q <= CPS_FLASH;
        end
        CPS_VERSION: begin
          if (!ver_keys) mode_q <= comm_q ? CPS_RUN : CPS_FLASH;
        end
        default: mode_q <= CPS_FLASH;
      endcase
    end
  end
  function automatic logic [GRP_W-1:0] lit(input logic [3:0] n);
    logic [GRP_W-1:0] r;
    r = '0;
    for (int i = 0; i < GRP_W; i++) begin
      if (i < n) r[i] = 1'b1;
    end
    return r;
  endfunction
  logic [63:0] ver_img;
  always_comb begin
    ver_img = 64'h0;
    ver_img[LEFT_LO +: GRP_W] = lit(VER_MAJOR);
    ver_img[CENTRE_LO +: GRP_W] = lit(VER_MINOR);
    ver_img[RIGHT_LO +: GRP_W] = lit(VER_PATCH);
  end

  ////////////////////////////////////////////////////////////////////////
  // led outputs from the output image, shadowed from the image word writes
  logic [63:0] led_img_q;
  logic [7:0] cust_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_img_q <= 64'h0;
      cust_q <= 8'h00;
    end else begin
      if (img.we && img.waddr == 2'h0) led_img_q[31:0] <= img.wdata;
      if (img.we && img.waddr == 2'h1) led_img_q[63:32] <= img.wdata;
      if (img.we && img.waddr == 2'h2) cust_q <= img.wdata[15:8];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_out <= 64'h0;
      cust_led_out <= 8'h00;
    end else begin
      case (mode_q)
        CPS_FLASH: begin
          led_out <= {64{blink_q}};
          cust_led_out <= {8{blink_q}};
        end
        CPS_VERSION: begin
          led_out <= ver_img;
          cust_led_out <= 8'h00;
        end
        default: begin
          led_out <= led_img_q;
          cust_led_out <= cust_q;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [include/cps_pkg.sv]
// Purpose: constants and types for the control panel fieldbus slave
// Assumes: 50 MHz pclk, APB register access
// Notes: Function
package cps_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int unsigned IN_BYTES = 17;
  localparam int unsigned OUT_BYTES = 10;
  localparam int unsigned STD_BYTES = 8;
  localparam int unsigned HW_BASE = 8;
  localparam int unsigned ADD_BASE = 12;
  localparam int unsigned CUST_LED_BYTE = 9;
  // byte addresses: input image words at 0x00, output image words at 0x40
  localparam logic [7:0] IN_BASE = 8'h00;
  localparam logic [7:0] OUT_BASE = 8'h40;
  localparam logic [7:0] CTRL_ADDR = 8'h80;
  localparam logic [7:0] STAT_ADDR = 8'h84;
  localparam logic [7:0] VER_ADDR = 8'h88;
  localparam int unsigned FEED_STOP_BIT = 22;
  localparam int unsigned FEED_EN_BIT = 23;
  localparam logic [3:0] VER_MAJOR = 4'h1;
  localparam logic [3:0] VER_MINOR = 4'h2;
  localparam logic [3:0] VER_PATCH = 4'h0;
  localparam int unsigned GRP_W = 8;
  localparam int unsigned LEFT_LO = 0;
  localparam int unsigned CENTRE_LO = 24;
  localparam int unsigned RIGHT_LO = 48;
  localparam logic [9:0] SEL_SHIPPED = 10'h000;
  typedef enum logic [1:0] {CPS_LINK_LEGACY, CPS_LINK_FIELDBUS} cps_link_t;
  typedef enum {CPS_FLASH, CPS_RUN, CPS_VERSION} cps_mode_t;
endpackage

// [include/cps_img_if.sv]
`timescale 1ns/1ns
`default_nettype none
// carries one image word write and a registered read
interface cps_img_if;
  logic we;
  logic [1:0] waddr;
  logic [31:0] wdata;
  logic [1:0] raddr;
  logic [31:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// [src/cps_out_mem.sv]
// Purpose: output image store, three words, registered read
// Assumes: single clock
// Notes: none
`timescale 1ns/1ns
`default_nettype none
module cps_out_mem
  import cps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  cps_img_if.mem bus
);
  logic [31:0] mem_q [3];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_q[0] <= 32'h0;
      mem_q[1] <= 32'h0;
      mem_q[2] <= 32'h0;
    end else if (bus.we && bus.waddr != 2'h3) begin
      mem_q[bus.waddr] <= bus.wdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.rdata <= 32'h0;
    end else begin
      bus.rdata <= (bus.raddr == 2'h3) ? 32'h0 : mem_q[bus.raddr];
    end
  end
endmodule
`default_nettype wire

// [tb/cps_master.sv]
// Purpose: fieldbus master model on apb
// Assumes: one transfer at a time
// Notes: released write data is inverted
`timescale 1ns/1ns
`default_nettype none
module cps_master (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb/cps_slave_chk.sv]
// Purpose: port assertions for cps_slave
// Assumes: inputs steady around each check
// Notes: bound to cps_slave
`timescale 1ns/1ns
`default_nettype none
module cps_slave_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [63:0] keys_in,
  input wire logic [15:0] hw1_count_in,
  input wire logic [15:0] hw2_count_in,
  input wire logic hw1_present,
  input wire logic hw2_present,
  input wire logic [15:0] direct_keys_in,
  input wire logic [5:0] cust_keys_in,
  input wire logic [7:0] rotary1_in,
  input wire logic [7:0] rotary2_in,
  input wire logic [9:0] rear_selector_switch,
  input wire logic [63:0] led_out,
  input wire logic [7:0] cust_led_out,
  input wire logic fieldbus_mode,
  input wire logic std_hardware,
  input wire logic [6:0] station_addr
);
  logic seen_q;
  logic [3:0] cnt_q, hold_q, calm_q;
  logic [71:0] in_q;
  wire [71:0] in_d = {hw1_count_in, hw2_count_in, hw1_present, hw2_present, direct_keys_in,
                      cust_keys_in, rotary1_in, rotary2_in};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {seen_q, cnt_q, hold_q, calm_q, in_q} <= '0;
    end else begin
      seen_q <= seen_q | (psel & penable & pready);
      cnt_q <= cnt_q + {3'h0, cnt_q != 4'hF};
      hold_q <= (keys_in[23:22] != 2'b11) ? 4'h0 : hold_q + {3'h0, hold_q != 4'hF};
      calm_q <= (in_d != in_q) ? 4'h0 : calm_q + {3'h0, calm_q != 4'hF};
      in_q <= in_d;
    end
  end
  sequence s_rd(logic [7:0] a);
    calm_q > 4'h6 && psel && penable && pready && !pwrite && paddr == a;
  endsequence
  chk_flash_all: assert property (!seen_q && hold_q == 4'h0 |->
    (led_out == '0 && cust_led_out == '0) || (&led_out && &cust_led_out))
    else $error("leds not flashing together");
  chk_version_show: assert property (hold_q == 4'hF |->
    led_out == 64'h3000001 && cust_led_out == 8'h00)
    else $error("version display wrong");
  chk_wheel_bytes: assert property (s_rd(8'h08) |-> prdata ==
    {hw2_present ? {hw2_count_in[7:0], hw2_count_in[15:8]} : 16'h0,
     hw1_present ? {hw1_count_in[7:0], hw1_count_in[15:8]} : 16'h0}) else $error("wheel word wrong");
  chk_add_bytes: assert property (s_rd(8'h0C) |->
    prdata == {rotary1_in, 2'b00, cust_keys_in, direct_keys_in}) else $error("additional word wrong");
  chk_resv_zero: assert property (s_rd(8'h48) |-> prdata[7:0] == 8'h00)
    else $error("reserved byte not zero");
  chk_link_type: assert property (cnt_q == 4'h8 |->
    fieldbus_mode == &rear_selector_switch[9:8])
    else $error("link type wrong");
  chk_hw_code: assert property (cnt_q == 4'h8 |-> std_hardware == !rear_selector_switch[7])
    else $error("hardware code wrong");
  chk_station_addr: assert property (cnt_q == 4'h8 |-> station_addr == rear_selector_switch[6:0])
    else $error("station address wrong");
  chk_sel_held: assert property (cnt_q == 4'hF |-> $stable({fieldbus_mode, std_hardware, station_addr}))
    else $error("selector decode moved");
  chk_led_write: assert property (seen_q && hold_q == 4'h0 && psel && penable && pready && pwrite
    && paddr == 8'h40 |-> ##2 led_out[31:0] == $past(pwdata, 2)) else $error("led image not shown");
endmodule
bind cps_slave cps_slave_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .keys_in, .hw1_count_in, .hw2_count_in, .hw1_present, .hw2_present,
  .direct_keys_in, .cust_keys_in, .rotary1_in, .rotary2_in, .rear_selector_switch, .led_out,
  .cust_led_out, .fieldbus_mode, .std_hardware, .station_addr);
`default_nettype wire

// [tb/cps_slave_bench.sv]
// Purpose: self-checking bench for cps_slave
// Assumes: master model drives apb
// Notes: each selector case takes a fresh reset
`timescale 1ns/1ns
`default_nettype none
module cps_slave_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err, fieldbus_mode, std_hardware;
  logic hw1_present = 1'b1;
  logic hw2_present = 1'b0;
  logic [7:0] paddr, cust_led_out;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] keys_in = 64'h0123456789ABCDEF;
  logic [63:0] led_out;
  logic [15:0] hw1_count_in = 16'h1234;
  logic [15:0] hw2_count_in = 16'hABCD;
  logic [15:0] direct_keys_in = 16'h5AC3;
  logic [5:0] cust_keys_in = 6'h25;
  logic [7:0] rotary1_in = 8'h81;
  logic [7:0] rotary2_in = 8'h7E;
  logic [9:0] rear_selector_switch = 10'h355;
  logic [6:0] station_addr;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  always #10 pclk = ~pclk;
  cps_master mst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  cps_slave DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .keys_in, .hw1_count_in, .hw2_count_in, .hw1_present, .hw2_present, .direct_keys_in,
    .cust_keys_in, .rotary1_in, .rotary2_in, .rear_selector_switch, .led_out, .cust_led_out,
    .fieldbus_mode, .std_hardware, .station_addr);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdw(input logic [7:0] a, input logic [31:0] e);
    mst.xfer(1'b0, a, 32'h0, rd, err);
    cmp("read word", {24'h0, a, e}, {24'h0, a, rd});
  endtask
  task automatic reboot(input logic [9:0] s);
    rear_selector_switch <= s;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_select();
    logic [9:0] s [3] = '{10'h355, 10'h000, 10'h3FF};
    foreach (s[i]) begin
      reboot(s[i]);
      cmp("link", {63'h0, s[i][9] & s[i][8]}, {63'h0, fieldbus_mode});
      cmp("hw code", {63'h0, !s[i][7]}, {63'h0, std_hardware});
      cmp("station", {57'h0, s[i][6:0]}, {57'h0, station_addr});
      cmp("flash leds", 64'h0, led_out);
      cmp("flash cust", 64'h0, {56'h0, cust_led_out});
    end
    rear_selector_switch <= 10'h000;
    repeat (10) @(posedge pclk);
    cmp("held", {55'h0, 9'h17F}, {55'h0, fieldbus_mode, std_hardware, station_addr});
  endtask
  task automatic t_inputs();
    rdw(8'h00, 32'h89ABCDEF);
    rdw(8'h04, 32'h01234567);
    rdw(8'h08, 32'h00003412);
    rdw(8'h0C, 32'h81255AC3);
    rdw(8'h10, 32'h0000007E);
    hw1_present <= 1'b0;
    hw2_present <= 1'b1;
    repeat (8) @(posedge pclk);
    rdw(8'h08, 32'hCDAB0000);
  endtask
  task automatic t_outputs();
    mst.xfer(1'b1, 8'h40, 32'hA5A50F0F, rd, err);
    mst.xfer(1'b1, 8'h44, 32'h12345678, rd, err);
    mst.xfer(1'b1, 8'h48, 32'h0000C300, rd, err);
    repeat (4) @(posedge pclk);
    cmp("led image", 64'h12345678A5A50F0F, led_out);
    cmp("cust leds", 64'hC3, {56'h0, cust_led_out});
    rdw(8'h48, 32'h0000C300);
  endtask
  task automatic t_version();
    keys_in <= 64'h0000000000C00000;
    repeat (20) @(posedge pclk);
    cmp("version leds", 64'h0000000003000001, led_out);
    cmp("version cust", 64'h0, {56'h0, cust_led_out});
    keys_in <= 64'h0;
    repeat (20) @(posedge pclk);
    cmp("image back", 64'h12345678A5A50F0F, led_out);
    mst.xfer(1'b0, 8'hFC, 32'h0, rd, err);
    cmp("unmapped", 64'h0000000100000000, {31'h0, err, rd});
    rdw(8'h88, 32'h00000120);
    mst.xfer(1'b1, 8'h80, 32'h0, rd, err);
    repeat (3) @(posedge pclk);
    cmp("flash again", 64'h0, led_out);
    rdw(8'h84, 32'h00000FF4);
    rdw(8'h80, 32'h00000001);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    t_select();
    t_inputs();
    t_outputs();
    t_version();
    print_verdict();
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
endmodule
`default_nettype wire
